// ==== hdl/par_port.sv ====
// parallel ports A..E with the strobe/handshake engine on ports B and C
// assumes wishbone classic master on clk_i, synchronous reset, pins from outside
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module par_port
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [par_port_pkg::ADR_W-1:0] adr_i,
    input wire logic [par_port_pkg::DAT_W-1:0] dat_i,
    input wire logic [par_port_pkg::SEL_W-1:0] sel_i,
    output logic [par_port_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic [1:0] mode_i,
    input wire logic [7:0] addr_hi_i,
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe_o,
    input wire logic oc3_en_i,
    input wire logic oc3_val_i,
    input wire logic oc7_en_i,
    input wire logic oc7_val_i,
    output logic pulse_acc_o,
    output logic [7:0] port_b_o,
    input wire logic [7:0] pc_i,
    output logic [7:0] pc_o,
    output logic [7:0] pc_oe_o,
    input wire logic [7:0] ext_ad_i,
    input wire logic ext_ad_oe_i,
    output logic ext_port_c_access_o,
    input wire logic [par_port_pkg::PD_W-1:0] pd_i,
    output logic [par_port_pkg::PD_W-1:0] pd_o,
    output logic [par_port_pkg::PD_W-1:0] pd_oe_o,
    input wire logic [par_port_pkg::PD_W-1:0] sci_spi_en_i,
    input wire logic [par_port_pkg::PD_W-1:0] sci_spi_val_i,
    input wire logic [par_port_pkg::PD_W-1:0] sci_spi_oe_i,
    input wire logic spi_master_select_i,
    output logic mode_fault_enable_o,
    input wire logic [7:0] pe_i,
    input wire logic strobe_a_input_i,
    output logic strobe_b_output_o,
    output logic strobe_a_irq_o
);
    import par_port_pkg::*;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [7:0] pa_f, pc_f, pe_f;
    logic [PD_W-1:0] pd_f;
    logic sa_f, sa_prev_q;
    logic [1:0] mode_q;
    logic ack_q;
    logic [DAT_W-1:0] dat_q;
    logic [7:0] pulse_count_port_a_ctrl_q, pa_data_q, pb_data_q, pc_data_q, pc_dir_q, latch_q;
    logic [PD_W-1:0] pd_data_q, pd_dir_q;
    logic [6:0] ctrl_q;
    logic strobe_a_flag_q, strobe_a_flag_arm_q;
    strobe_b_output_state_t sb_state_q;
    logic [1:0] sb_cnt_q;
    logic [7:0] rd8;
    logic [IDX_W-1:0] idx;
    logic req, wr, rd, chip_only, hs_on, simple, in_hs, out_hs;
    logic sa_edge, sa_level, strobe_a_flag_clear, sb_trig, sb_act, pd5_gp;
    logic [7:0] pc_oe_raw;
    logic [PD_W-1:0] pd_en_eff;
    // three-stage sampling; a bit moves only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
            filt_q <= SYNC_RST;
        end else begin
            s1_q <= {strobe_a_input_i, pe_i, pd_i, pc_i, pa_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end

    assign pa_f = filt_q[7:0];
    assign pc_f = filt_q[15:8];
    assign pd_f = filt_q[21:16];
    assign pe_f = filt_q[29:22];
    assign sa_f = filt_q[30];
    // mode straps taken while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= mode_i;
        end
    end

    assign chip_only = (mode_q == MODE_SINGLE) || (mode_q == MODE_BOOT);
    assign hs_on = (mode_q == MODE_SINGLE);
    assign simple = hs_on & ~ctrl_q[FULL_HANDSHAKE_SELECT_BIT];
    assign in_hs = hs_on & ctrl_q[FULL_HANDSHAKE_SELECT_BIT] & ~ctrl_q[OIN_BIT];
    assign out_hs = hs_on & ctrl_q[FULL_HANDSHAKE_SELECT_BIT] & ctrl_q[OIN_BIT];

    assign req = cyc_i & stb_i & ~ack_q;
    assign wr = req & we_i & sel_i[0];
    assign rd = req & ~we_i;
    assign idx = adr_i[ADR_W-1:IDX_LSB];
    assign sa_edge = ctrl_q[EGA_BIT] ? (sa_f & ~sa_prev_q) : (~sa_f & sa_prev_q);
    assign sa_level = ctrl_q[EGA_BIT] ? ~sa_f : sa_f;

    always_comb begin
        rd8 = DATA_RST;
        if (idx == IDX_PORT_A) begin
            rd8 = {pa_f[7], pa_data_q[6:4], pa_f[3:0]};
        end else if (idx == IDX_PAR_CTRL) begin
            rd8 = {strobe_a_flag_q, ctrl_q};
        end else if (idx == IDX_PORT_C && chip_only) begin
            rd8 = (pc_dir_q & pc_data_q) | (~pc_dir_q & pc_f);
        end else if (idx == IDX_PORT_B) begin
            rd8 = pb_data_q;
        end else if (idx == IDX_ALT_LATCH) begin
            rd8 = latch_q;
        end else if (idx == IDX_PORT_C_DIR) begin
            rd8 = pc_dir_q;
        end else if (idx == IDX_PORT_D) begin
            rd8 = {2'h0, (pd_dir_q & pd_data_q) | (~pd_dir_q & pd_f)};
        end else if (idx == IDX_PORT_D_DIR) begin
            rd8 = {2'h0, pd_dir_q};
        end else if (idx == IDX_PORT_E) begin
            rd8 = pe_f;
        end else if (idx == IDX_PULSE_CTRL) begin
            rd8 = pulse_count_port_a_ctrl_q;
        end
    end
    // one wait state; unmapped indices answer with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= BUS_ZERO;
        end else begin
            ack_q <= req;
            if (rd) begin
                dat_q <= {24'h00_0000, rd8};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_port_c_access_o <= 1'b0;
        end else begin
            ext_port_c_access_o <= req & ~chip_only & (idx == IDX_PORT_C);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_count_port_a_ctrl_q <= PULSE_CTRL_RST;
            pa_data_q <= DATA_RST;
            pb_data_q <= DATA_RST;
            pc_data_q <= DATA_RST;
            pc_dir_q <= DIR_RST;
            pd_data_q <= PD_DIR_RST;
            pd_dir_q <= PD_DIR_RST;
            ctrl_q <= PAR_CTRL_RST;
        end else if (wr) begin
            if (idx == IDX_PULSE_CTRL) begin
                pulse_count_port_a_ctrl_q <= dat_i[7:0];
            end else if (idx == IDX_PORT_A) begin
                pa_data_q <= dat_i[7:0];
            end else if (idx == IDX_PORT_B) begin
                pb_data_q <= dat_i[7:0];
            end else if (idx == IDX_PORT_C && chip_only) begin
                pc_data_q <= dat_i[7:0];
            end else if (idx == IDX_ALT_LATCH) begin
                pc_data_q <= dat_i[7:0];
            end else if (idx == IDX_PORT_C_DIR) begin
                pc_dir_q <= dat_i[7:0];
            end else if (idx == IDX_PORT_D) begin
                pd_data_q <= dat_i[PD_W-1:0];
            end else if (idx == IDX_PORT_D_DIR) begin
                pd_dir_q <= dat_i[PD_W-1:0];
            end else if (idx == IDX_PAR_CTRL) begin
                ctrl_q <= dat_i[6:0];
            end
        end
    end
    // alternate latch: pin capture on strobe A edge in single-chip mode outside output handshake, software write otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= DATA_RST;
            sa_prev_q <= 1'b1;
        end else begin
            sa_prev_q <= sa_f;
            if (hs_on && sa_edge && !out_hs) begin
                latch_q <= pc_f;
            end else if (wr && idx == IDX_ALT_LATCH) begin
                latch_q <= dat_i[7:0];
            end
        end
    end
    // flag clear: control read seeing flag set, then latch read (write in output mode)
    assign strobe_a_flag_clear = strobe_a_flag_arm_q & ((rd & ~out_hs & (idx == IDX_ALT_LATCH))
                                     | (wr & out_hs & (idx == IDX_ALT_LATCH)));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_a_flag_q <= 1'b0;
            strobe_a_flag_arm_q <= 1'b0;
        end else begin
            // a new edge beats a clear in the same cycle
            if (hs_on && sa_edge) begin
                strobe_a_flag_q <= 1'b1;
            end else if (strobe_a_flag_clear) begin
                strobe_a_flag_q <= 1'b0;
            end
            if (rd && idx == IDX_PAR_CTRL) begin
                strobe_a_flag_arm_q <= strobe_a_flag_q;
            end else if (strobe_a_flag_clear) begin
                strobe_a_flag_arm_q <= 1'b0;
            end
        end
    end
    // strobe B sources: port B write, latch read, latch write, input mode entry
    assign sb_trig = (simple & wr & (idx == IDX_PORT_B))
                   | (in_hs & rd & (idx == IDX_ALT_LATCH))
                   | (out_hs & wr & (idx == IDX_ALT_LATCH))
                   | (hs_on & wr & (idx == IDX_PAR_CTRL)
                      & dat_i[FULL_HANDSHAKE_SELECT_BIT] & ~dat_i[OIN_BIT]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sb_state_q <= SB_IDLE;
            sb_cnt_q <= 2'h0;
        end else if (!hs_on) begin
            sb_state_q <= SB_IDLE;
            sb_cnt_q <= 2'h0;
        end else if (sb_trig) begin
            // a control write judges by its new bits, not the simple mode it leaves
            if ((wr && idx == IDX_PAR_CTRL) ? dat_i[PLS_BIT] : (simple || ctrl_q[PLS_BIT])) begin
                sb_state_q <= SB_PULSE;
                sb_cnt_q <= STROBE_B_OUTPUT_PULSE_CYCLES;
            end else begin
                sb_state_q <= SB_HOLD;
            end
        end else begin
            case (sb_state_q)
                SB_PULSE: begin
                    if (sb_cnt_q == STROBE_B_OUTPUT_CNT_LAST) begin
                        sb_state_q <= SB_IDLE;
                    end
                    sb_cnt_q <= sb_cnt_q - 2'h1;
                end
                SB_HOLD: begin
                    // the selected edge is the trailing edge of the active level
                    if (sa_edge) begin
                        sb_state_q <= SB_IDLE;
                    end
                end
                default: begin
                    sb_state_q <= SB_IDLE;
                end
            endcase
        end
    end

    assign sb_act = (sb_state_q != SB_IDLE);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_b_output_o <= 1'b1;
            strobe_a_irq_o <= 1'b0;
        end else begin
            strobe_b_output_o <= ctrl_q[STROBE_B_INVERT_BIT] ? sb_act : ~sb_act;
            strobe_a_irq_o <= strobe_a_flag_q & ctrl_q[STROBE_A_IRQ_ENABLE_BIT];
        end
    end
    // port A: pins 2..0 inputs, 6..4 outputs, 7 and 3 bidirectional
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_o <= DATA_RST;
            pa_oe_o <= DIR_RST;
            pulse_acc_o <= 1'b0;
        end else begin
            pa_o <= {oc7_en_i ? oc7_val_i : pa_data_q[7], pa_data_q[6:4],
                     oc3_en_i ? oc3_val_i : pa_data_q[3], 3'h0};
            pa_oe_o <= {oc7_en_i | pulse_count_port_a_ctrl_q[PIN7_DIR_BIT], 3'h7,
                        oc3_en_i | pulse_count_port_a_ctrl_q[PIN3_DIR_BIT], 3'h0};
            pulse_acc_o <= pa_f[7];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_o <= DATA_RST;
        end else begin
            port_b_o <= chip_only ? pb_data_q : addr_hi_i;
        end
    end
    // active strobe A in output handshake enables every line regardless of direction; in wired-or mode the lines holding a one stay released
    assign pc_oe_raw = (out_hs & sa_level) ? '1 : pc_dir_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= DATA_RST;
            pc_oe_o <= DIR_RST;
        end else if (!chip_only) begin
            pc_o <= ext_ad_i;
            pc_oe_o <= {8{ext_ad_oe_i}};
        end else begin
            pc_o <= pc_data_q;
            // wired-or: only ever pull low, release for a one
            pc_oe_o <= ctrl_q[CWOM_BIT] ? (pc_oe_raw & ~pc_data_q) : pc_oe_raw;
        end
    end
    // port D: peripheral takes a pin unless pin 5 is a gp output under SPI master
    assign pd5_gp = pd_dir_q[PD_SS_BIT] & spi_master_select_i;
    assign pd_en_eff = sci_spi_en_i & ~({1'b1, 5'h00} & {PD_W{pd5_gp}});
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_o <= PD_DIR_RST;
            pd_oe_o <= PD_DIR_RST;
            mode_fault_enable_o <= 1'b1;
        end else begin
            pd_o <= (pd_en_eff & sci_spi_val_i) | (~pd_en_eff & pd_data_q);
            pd_oe_o <= (pd_en_eff & sci_spi_oe_i) | (~pd_en_eff & pd_dir_q);
            mode_fault_enable_o <= ~pd5_gp;
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    strobe_a_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hs_on && sa_edge) |=> strobe_a_flag_q ##1
        strobe_a_irq_o == ($past(strobe_a_flag_q) && $past(ctrl_q[STROBE_A_IRQ_ENABLE_BIT])))
        else $error("strobe A flag not set on selected edge");
    latch_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hs_on && sa_edge && !out_hs) |=> latch_q == $past(pc_f))
        else $error("alternate latch missed port C capture");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe_a_flag_q && !strobe_a_flag_arm_q && rd && idx == IDX_ALT_LATCH && !(hs_on && sa_edge))
        |=> strobe_a_flag_q)
        else $error("flag cleared without prior control read");
    strobe_b_output_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (simple && wr && idx == IDX_PORT_B) |=> sb_act[*2] ##1 !sb_act)
        else $error("strobe B pulse not two clocks");
    strobe_b_output_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 strobe_b_output_o == ($past(ctrl_q[STROBE_B_INVERT_BIT]) ? $past(sb_act) : !$past(sb_act)))
        else $error("strobe B polarity wrong");
    hold_negate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sb_state_q == SB_HOLD && sa_edge && !sb_trig && hs_on) |=> !sb_act ##1 !strobe_b_output_o
        == ctrl_q[STROBE_B_INVERT_BIT])
        else $error("strobe B not negated on strobe A edge");
    port_b_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && !chip_only) |=> port_b_o == $past(addr_hi_i))
        else $error("port B not carrying high address");
    three_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (out_hs && sa_level && !ctrl_q[CWOM_BIT]) |=> pc_oe_o == 8'hFF && pc_o == $past(pc_data_q))
        else $error("port C not driven during active strobe A");
    reset_dir_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> pc_dir_q == DIR_RST && pd_dir_q == PD_DIR_RST && pc_oe_o == DIR_RST)
        else $error("direction bits not cleared by reset");
    mode_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pd_dir_q[PD_SS_BIT] && spi_master_select_i) |=> !mode_fault_enable_o
        && pd_oe_o[PD_SS_BIT] && pd_o[PD_SS_BIT] == $past(pd_data_q[PD_SS_BIT]))
        else $error("pin 5 not general output under SPI master");
    pin7_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!oc7_en_i && !pulse_count_port_a_ctrl_q[PIN7_DIR_BIT]) |=> !pa_oe_o[7] ##2 pulse_acc_o == $past(pa_f[7]))
        else $error("pin 7 direction or accumulator feed wrong");

endmodule

// ==== hdl/par_port_pkg.sv ====
// constants, register indices and types for the parallel port block
// assumes a classic wishbone master with 32-bit data; registers are 8 bits wide
package par_port_pkg;

    localparam int ADR_W = 16;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_W = 14;
    localparam int IDX_LSB = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PORT_A = 14'h1000;
    localparam logic [IDX_W-1:0] IDX_PAR_CTRL = 14'h1002;
    localparam logic [IDX_W-1:0] IDX_PORT_C = 14'h1003;
    localparam logic [IDX_W-1:0] IDX_PORT_B = 14'h1004;
    localparam logic [IDX_W-1:0] IDX_ALT_LATCH = 14'h1005;
    localparam logic [IDX_W-1:0] IDX_PORT_C_DIR = 14'h1007;
    localparam logic [IDX_W-1:0] IDX_PORT_D = 14'h1008;
    localparam logic [IDX_W-1:0] IDX_PORT_D_DIR = 14'h1009;
    localparam logic [IDX_W-1:0] IDX_PORT_E = 14'h100A;
    localparam logic [IDX_W-1:0] IDX_PULSE_CTRL = 14'h1026;

    // pulse_count_port_a_ctrl fields
    localparam int PIN7_DIR_BIT = 7;
    localparam int PIN3_DIR_BIT = 3;

    // parallel_control fields
    localparam int STROBE_A_FLAG_BIT = 7;
    localparam int STROBE_A_IRQ_ENABLE_BIT = 6;
    localparam int CWOM_BIT = 5;
    localparam int FULL_HANDSHAKE_SELECT_BIT = 4;
    localparam int OIN_BIT = 3;
    localparam int PLS_BIT = 2;
    localparam int EGA_BIT = 1;
    localparam int STROBE_B_INVERT_BIT = 0;

    localparam logic [7:0] PULSE_CTRL_RST = 8'h00;
    localparam logic [6:0] PAR_CTRL_RST = 7'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [5:0] PD_DIR_RST = 6'h00;
    localparam logic [DAT_W-1:0] BUS_ZERO = 32'h0000_0000;

    localparam int PD_W = 6;
    localparam int PD_SS_BIT = 5;
    localparam int SYNC_W = 31;
    // strobe A idles high; its stages reset high so no false edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 31'h4000_0000;

    // operating mode straps
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXPANDED = 2'h1;
    localparam logic [1:0] MODE_BOOT = 2'h2;
    localparam logic [1:0] MODE_TEST = 2'h3;

    // strobe B pulse length in bus clocks
    localparam logic [1:0] STROBE_B_OUTPUT_PULSE_CYCLES = 2'h2;
    localparam logic [1:0] STROBE_B_OUTPUT_CNT_LAST = 2'h1;

    typedef enum logic [1:0] {SB_IDLE, SB_PULSE, SB_HOLD} strobe_b_output_state_t;

endpackage

// ==== tb/parallel_ports_strobe_handshake_test.sv ====
// self-checking bench for the parallel port block over wishbone
// assumes strobe_peer on the strobe A and port C pins
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: %h not %h", $time, (a), (b)); end end
module parallel_ports_strobe_handshake_test;
    import par_port_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, oc3_en_i = 0, oc3_val_i = 0;
    logic oc7_en_i = 0, oc7_val_i = 0, ext_ad_oe_i = 0, spi_master_select_i = 0;
    logic ack_o, pulse_acc_o, ext_port_c_access_o, mode_fault_enable_o;
    logic strobe_a_input_i, strobe_b_output_o, strobe_a_irq_o;
    logic [1:0] mode_i = MODE_SINGLE;
    logic [ADR_W-1:0] adr_i = '0;
    logic [DAT_W-1:0] dat_i = '0, dat_o;
    logic [SEL_W-1:0] sel_i = 4'h1;
    logic [7:0] addr_hi_i, pa_i = 8'h00, pa_o, pa_oe_o, port_b_o, pc_i, pc_o, pc_oe_o;
    logic [7:0] ext_ad_i, pe_i, r, d;
    logic [PD_W-1:0] pd_i, pd_o, pd_oe_o, sci_spi_en_i = '0, sci_spi_val_i, sci_spi_oe_i;
    int err_total = 0, cmp_count = 0, cyc_n = 0, n, ext_n = 0;

    par_port dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o,
        .ack_o, .mode_i, .addr_hi_i, .pa_i, .pa_o, .pa_oe_o, .oc3_en_i, .oc3_val_i,
        .oc7_en_i, .oc7_val_i, .pulse_acc_o, .port_b_o, .pc_i, .pc_o, .pc_oe_o, .ext_ad_i,
        .ext_ad_oe_i, .ext_port_c_access_o, .pd_i, .pd_o, .pd_oe_o, .sci_spi_en_i,
        .sci_spi_val_i, .sci_spi_oe_i, .spi_master_select_i, .mode_fault_enable_o, .pe_i,
        .strobe_a_input_i, .strobe_b_output_o, .strobe_a_irq_o);
    strobe_peer peer (.clk_i(clk_i), .strobe_a_o(strobe_a_input_i), .pc_o(pc_i));

    always #2.5 clk_i = ~clk_i;

    task automatic end_sim;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        ext_n <= ext_n + (ext_port_c_access_o === 1'b1);
        if (cyc_n == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic wb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
        output logic [7:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h00_0000, wd};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
        logic [7:0] q;
        wb(1'b1, idx, wd, q);
    endtask

    task automatic cnt_b(input logic lvl);
        n = 0;
        repeat (10) begin
            @(posedge clk_i);
            if (strobe_b_output_o === lvl) n++;
        end
    endtask

    initial begin
        void'($urandom(32'hc2d9));
        {addr_hi_i, ext_ad_i, pe_i} = $urandom;
        {pd_i, sci_spi_val_i, sci_spi_oe_i} = $urandom;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK(pa_oe_o, 8'h70)
        `CHK(strobe_b_output_o, 1'b1)
        `CHK(pc_oe_o, 8'h00)
        `CHK(pd_oe_o, PD_DIR_RST)
        wb(1'b0, IDX_PULSE_CTRL, 8'h00, r);
        `CHK(r, PULSE_CTRL_RST)
        wb(1'b0, IDX_PORT_C_DIR, 8'h00, r);
        `CHK(r, DIR_RST)
        wb(1'b0, IDX_PORT_D_DIR, 8'h00, r);
        `CHK(r, 8'h00)
        $display("reset test done");
        repeat (4) begin
            d = $urandom;
            wr(IDX_PULSE_CTRL, d);
            wb(1'b0, IDX_PULSE_CTRL, 8'h00, r);
            `CHK(r, d)
            `CHK(pa_oe_o, {d[7], 3'h7, d[3], 3'h0})
        end
        wr(IDX_PULSE_CTRL, 8'h80);
        pa_i[7] <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(pulse_acc_o, 1'b1)
        oc7_en_i <= 1'b1;
        oc7_val_i <= 1'b1;
        oc3_en_i <= 1'b1;
        wr(IDX_PULSE_CTRL, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(pa_oe_o[7], 1'b1)
        `CHK(pa_oe_o[3], 1'b1)
        `CHK(pa_o[7], 1'b1)
        $display("port a test done");
        for (int i = 0; i < 2; i++) begin
            wr(IDX_PAR_CTRL, 8'(i));
            d = $urandom;
            // the pulse begins before wr returns, so count alongside the write
            fork
                wr(IDX_PORT_B, d);
                cnt_b(i[0]);
            join
            `CHK(n, 2)
            `CHK(port_b_o, d)
        end
        $display("strobe b test done");
        wr(IDX_PAR_CTRL, 8'h40);
        d = $urandom;
        peer.send(d);
        wb(1'b0, IDX_ALT_LATCH, 8'h00, r);
        `CHK(r, d)
        wb(1'b0, IDX_PAR_CTRL, 8'h00, r);
        `CHK(r[7], 1'b1)
        `CHK(strobe_a_irq_o, 1'b1)
        wb(1'b0, IDX_ALT_LATCH, 8'h00, r);
        wb(1'b0, IDX_PAR_CTRL, 8'h00, r);
        `CHK(r[7], 1'b0)
        wr(IDX_PAR_CTRL, 8'h02);
        d = $urandom;
        peer.send(d);
        wb(1'b0, IDX_ALT_LATCH, 8'h00, r);
        `CHK(r, d)
        $display("flag test done");
        wr(IDX_PAR_CTRL, 8'h10);
        repeat (2) @(posedge clk_i);
        `CHK(strobe_b_output_o, 1'b0)
        d = $urandom;
        peer.send(d);
        `CHK(strobe_b_output_o, 1'b1)
        wb(1'b0, IDX_PAR_CTRL, 8'h00, r);
        wb(1'b0, IDX_ALT_LATCH, 8'h00, r);
        `CHK(r, d)
        @(posedge clk_i);
        `CHK(strobe_b_output_o, 1'b0)
        wr(IDX_PORT_C_DIR, 8'h00);
        wr(IDX_PAR_CTRL, 8'h18);
        d = $urandom;
        wr(IDX_ALT_LATCH, d);
        @(posedge clk_i);
        `CHK(strobe_b_output_o, 1'b0)
        `CHK(pc_oe_o, 8'hFF)
        `CHK(pc_o, d)
        peer.send(~d);
        `CHK(strobe_b_output_o, 1'b1)
        $display("handshake test done");
        spi_master_select_i <= 1'b1;
        wr(IDX_PORT_D_DIR, 8'hFF);
        wb(1'b0, IDX_PORT_D_DIR, 8'h00, r);
        `CHK(r, 8'h3F)
        `CHK(mode_fault_enable_o, 1'b0)
        `CHK(pd_oe_o[PD_SS_BIT], 1'b1)
        mode_i <= MODE_EXPANDED;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK(port_b_o, addr_hi_i)
        wb(1'b0, IDX_PORT_C, 8'h00, r);
        `CHK(r, 8'h00)
        `CHK(ext_n, 1)
        `CHK(pc_o, ext_ad_i)
        wb(1'b0, IDX_PORT_E, 8'h00, r);
        `CHK(r, pe_i)
        $display("mode test done");
        end_sim();
    end
endmodule

// ==== tb/strobe_peer.sv ====
// far-side parallel peripheral: drives the strobe A pin and the port C pin levels
// assumes the bench calls send() just after a rising clock edge
`timescale 1ns/1ps
module strobe_peer (
    input wire logic clk_i,
    output logic strobe_a_o,
    output logic [7:0] pc_o
);
    initial begin
        strobe_a_o = 1'b1;
        pc_o = 8'h00;
    end
    // data held well past the edge so the pin filter sees it settled
    task automatic send(input logic [7:0] b);
        pc_o <= b;
        repeat (4) @(posedge clk_i);
        strobe_a_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        strobe_a_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        // released lines show the inverse, not the last byte
        pc_o <= ~b;
    endtask
endmodule
